/* File: mhsl_top.sv */
// modem handshake lines, status indicators and general-purpose pins
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - with hardware flow, clear-to-send goes low when the device can accept and forward host data, else high; without it, low unless disconnecting.
// - carrier-detect is low only while a data connection is up and the device is ready.
// - terminal-ready going high is ignored, enters command mode, or disconnects, per the response setting.
// - the duplex indicator is low whenever the link runs full duplex.
// - the activity indicator toggles 50 ms high, 50 ms low while traffic flows.
// - the link indicator is low whenever a good link is detected.
// - the network indicator is off when carrier function is off or in sleep or alarm.
// - the network indicator blinks 600 ms on and off while registering or searching.
// - with contexts active it repeats 75 on, 75 off, 75 on, 3 s off.
// - during packet transfer it lights within 1 s and each flash lasts about 0.5 s.
// - the network indicator is steady on during a connected or negotiating call.
// - each general-purpose pin is set to input or output by command, all pins together on one config strobe.
module mhsl_top import mhsl_pkg::*; #(
    parameter int MS_CYCLES = CYC_PER_MS
) (
    input wire logic clk, // 40 MHz system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic dtr_n, // terminal-ready pin from host, asynchronous
    input wire logic [1:0] terminal_ready_response_setting, // reaction to terminal-ready off
    input wire logic [1:0] flow_control_setting, // flow control mode
    input wire mhsl_link_t lnk, // link status from modem core
    input wire mhsl_net_t net, // network status from modem core
    input wire logic gpio_cfg_we, // one-cycle strobe: load pin config
    input wire logic [NUM_GPIO-1:0] gpio_cfg_dir, // 1 = output
    input wire logic [NUM_GPIO-1:0] gpio_cfg_out, // output levels
    input wire logic [NUM_GPIO-1:0] gpio_i, // pin levels, asynchronous
    output logic cts_n, // clear to send, active low
    output logic dcd_n, // carrier detect, active low
    output logic duplex_indicator_n, // duplex led, active low
    output logic activity_indicator_n, // activity led, active low
    output logic link_indicator_n, // link led, active low
    output logic net_led_n, // network status led, active low
    output logic hangup_req, // pulse: drop the call
    output logic cmd_mode_req, // pulse: enter command mode, keep call
    output logic soft_reset_req, // pulse: reset modem settings
    output logic [NUM_GPIO-1:0] gpio_o, // pin output level
    output logic [NUM_GPIO-1:0] gpio_oe, // pin output enable
    output logic [NUM_GPIO-1:0] gpio_in // synchronised pin level
);
    mhsl_st_t st_q;
    mhsl_st_t st_d;
    logic ms_tick;
    logic dtr_edge;
    logic net_quiet;
    logic net_seek;

    mhsl_ms_tick #(
        .CYC_PER_MS(MS_CYCLES)
    ) u_tick (
        .clk(clk),
        .rst(rst),
        .tick(ms_tick)
    );

    // length of each phase of a network pattern
    function automatic logic [11:0] phase_len(input mhsl_nm_t nm, input logic [1:0] ph);
        case (nm)
            NM_SEARCH: phase_len = SLOW_HALF_MS;
            NM_CTX: phase_len = (ph == 2'h3) ? CTX_GAP_MS : CTX_BLIP_MS;
            NM_XFER: phase_len = FLASH_MS;
            default: phase_len = 12'hFFF;
        endcase
    endfunction : phase_len

    function automatic logic [1:0] last_phase(input mhsl_nm_t nm);
        last_phase = (nm == NM_CTX) ? 2'h3 : 2'h1;
    endfunction : last_phase

    assign dtr_edge = st_q.dtr_sync[1] && !st_q.dtr_off;
    assign net_quiet = !net.carrier_on || net.sleep || net.alarm;
    assign net_seek = net.no_sim || net.no_pin || net.searching || net.authenticating
        || net.logging_in;

    always_comb begin
        st_d = st_q;
        st_d.dtr_sync = {st_q.dtr_sync[0], dtr_n};
        st_d.dtr_off = st_q.dtr_sync[1];
        st_d.hangup = 1'b0;
        st_d.cmd_mode = 1'b0;
        st_d.soft_reset = 1'b0;

        // ------------------------------------------------------------
        // connection and disconnect
        // ------------------------------------------------------------
        case (st_q.lk)
            LK_IDLE: begin
                if (lnk.data_conn && !st_q.dtr_sync[1]) begin
                    st_d.lk = LK_ONLINE;
                end
            end
            LK_ONLINE: begin
                if (!lnk.data_conn) begin
                    st_d.lk = LK_IDLE;
                end else if (dtr_edge) begin
                    case (terminal_ready_response_setting)
                        DR_CMD: st_d.cmd_mode = 1'b1;
                        DR_HANGUP: begin
                            st_d.hangup = 1'b1;
                            st_d.lk = LK_DISC;
                        end
                        DR_RESET: begin
                            st_d.hangup = 1'b1;
                            st_d.soft_reset = 1'b1;
                            st_d.lk = LK_DISC;
                        end
                        default: st_d.lk = LK_ONLINE;
                    endcase
                end
            end
            LK_DISC: begin
                // stay down until the call is gone and the host is ready again
                if (!lnk.data_conn && !st_q.dtr_sync[1]) begin
                    st_d.lk = LK_IDLE;
                end
            end
            default: st_d.lk = LK_IDLE;
        endcase
        st_d.dcd_n = !(st_d.lk == LK_ONLINE && lnk.data_conn && lnk.dev_ready);
        if (flow_control_setting == FC_HW) begin
            st_d.cts_n = !(lnk.fwd_ready && st_d.lk != LK_DISC);
        end else begin
            // without hardware flow the device always accepts unless disconnecting
            st_d.cts_n = (st_d.lk == LK_DISC);
        end

        // ------------------------------------------------------------
        // ethernet-style indicators
        // ------------------------------------------------------------
        st_d.fdx_n = !lnk.full_duplex;
        st_d.link_n = !lnk.link_good;
        if (!lnk.traffic) begin
            st_d.act_n = 1'b1;
            st_d.act_ms = '0;
        end else if (ms_tick) begin
            if (st_q.act_ms == ACT_HALF_MS - 6'h01) begin
                st_d.act_n = !st_q.act_n;
                st_d.act_ms = '0;
            end else begin
                st_d.act_ms = st_q.act_ms + 6'h01;
            end
        end

        // ------------------------------------------------------------
        // network status pattern
        // ------------------------------------------------------------
        if (net.pkt_seen) begin
            st_d.xfer_live = 1'b1;
            st_d.xfer_ms = '0;
        end else if (ms_tick && st_q.xfer_live) begin
            if (st_q.xfer_ms == XFER_HOLD_MS - 10'h001) begin
                st_d.xfer_live = 1'b0;
            end else begin
                st_d.xfer_ms = st_q.xfer_ms + 10'h001;
            end
        end
        if (net_quiet) begin
            st_d.nm = NM_OFF;
        end else if (net.voice_conn || net.data_call_busy) begin
            st_d.nm = NM_CALL;
        end else if (st_d.xfer_live) begin
            st_d.nm = NM_XFER;
        end else if (net.ctx_active) begin
            st_d.nm = NM_CTX;
        end else if (net_seek) begin
            st_d.nm = NM_SEARCH;
        end else begin
            st_d.nm = NM_OFF;
        end
        if (st_d.nm != st_q.nm) begin
            st_d.nphase = '0;
            st_d.net_ms = '0;
        end else if (ms_tick) begin
            if (st_q.net_ms == phase_len(st_q.nm, st_q.nphase) - 12'h001) begin
                st_d.net_ms = '0;
                st_d.nphase = (st_q.nphase == last_phase(st_q.nm)) ? 2'h0
                    : st_q.nphase + 2'h1;
            end else begin
                st_d.net_ms = st_q.net_ms + 12'h001;
            end
        end
        case (st_d.nm)
            NM_CALL: st_d.net_n = 1'b0;
            NM_OFF: st_d.net_n = 1'b1;
            default: st_d.net_n = st_d.nphase[0]; // even phases are lit
        endcase

        // ------------------------------------------------------------
        // general-purpose pins
        // ------------------------------------------------------------
        st_d.gi1 = gpio_i;
        st_d.gi2 = st_q.gi1;
        for (int i = 0; i < NUM_GPIO; i++) begin
            if (gpio_cfg_we) begin
                st_d.gdir[i] = gpio_cfg_dir[i];
                st_d.gout[i] = gpio_cfg_out[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign cts_n = st_q.cts_n;
    assign dcd_n = st_q.dcd_n;
    assign duplex_indicator_n = st_q.fdx_n;
    assign activity_indicator_n = st_q.act_n;
    assign link_indicator_n = st_q.link_n;
    assign net_led_n = st_q.net_n;
    assign hangup_req = st_q.hangup;
    assign cmd_mode_req = st_q.cmd_mode;
    assign soft_reset_req = st_q.soft_reset;
    assign gpio_o = st_q.gout;
    assign gpio_oe = st_q.gdir;
    assign gpio_in = st_q.gi2;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_cts_flow_stop: assert property (
        (flow_control_setting == FC_HW && !lnk.fwd_ready) |=> cts_n)
        else $error("clear-to-send low while unable to forward");
    a_dcd_needs_conn: assert property (
        !dcd_n |-> (st_q.lk == LK_ONLINE && $past(lnk.data_conn) && $past(lnk.dev_ready)))
        else $error("carrier-detect low without a connection");
    a_dtr_hangup: assert property (
        (st_q.lk == LK_ONLINE && dtr_edge && lnk.data_conn
            && terminal_ready_response_setting == DR_HANGUP)
        |=> (hangup_req && st_q.lk == LK_DISC && dcd_n))
        else $error("terminal-ready off did not hang up");
    a_dtr_ignored: assert property (
        (terminal_ready_response_setting == DR_IGNORE) |=> !(hangup_req || cmd_mode_req))
        else $error("terminal-ready acted on while ignored");
    a_fdx_follow: assert property (
        lnk.full_duplex |=> !duplex_indicator_n)
        else $error("duplex indicator not lit");
    a_link_follow: assert property (
        !lnk.link_good |=> link_indicator_n)
        else $error("link indicator lit without link");
    a_act_toggle: assert property (
        (lnk.traffic && ms_tick && st_q.act_ms == ACT_HALF_MS - 6'h01)
        |=> $changed(activity_indicator_n) && st_q.act_ms == 6'h00)
        else $error("activity indicator missed its 50 ms toggle");
    a_net_quiet_off: assert property (
        net_quiet |=> net_led_n)
        else $error("network indicator lit while quiet");
    a_net_call_on: assert property (
        (!net_quiet && net.voice_conn) |=> (!net_led_n && st_q.nm == NM_CALL))
        else $error("network indicator not steady during a call");
    a_net_restart: assert property (
        (st_d.nm != st_q.nm) |=> (st_q.nphase == 2'h0 && st_q.net_ms == 12'h000))
        else $error("pattern did not restart on a change");
    a_net_phase_len: assert property (
        (st_q.nm != NM_OFF && st_q.nm != NM_CALL)
        |-> st_q.net_ms < phase_len(st_q.nm, st_q.nphase))
        else $error("pattern phase ran past its length");
    a_xfer_over_ctx: assert property (
        (!net_quiet && !net.voice_conn && !net.data_call_busy && net.pkt_seen)
        |=> st_q.nm == NM_XFER)
        else $error("transfer pattern lost priority");
    a_gpio_config: assert property (
        gpio_cfg_we |=> (gpio_oe == $past(gpio_cfg_dir) && gpio_o == $past(gpio_cfg_out)))
        else $error("pin configuration not applied");

    c_hangup: cover property (st_q.lk == LK_ONLINE ##1 hangup_req);
    c_ctx_gap: cover property (st_q.nm == NM_CTX && st_q.nphase == 2'h3);
    c_act_blink: cover property (lnk.traffic && $fell(activity_indicator_n));
    c_xfer_flash: cover property (st_q.nm == NM_XFER && !net_led_n);

endmodule : mhsl_top
`default_nettype wire

/* File: mhsl_pkg.sv */
// shared types and constants for the modem handshake and status indicator block
package mhsl_pkg;

    // ------------------------------------------------------------
    // timing base
    // ------------------------------------------------------------
    localparam int MS_NS = 1000000;
    localparam int CLK_PERIOD_NS = 25;
    // least time: round up to whole cycles
    localparam int CYC_PER_MS = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // indicator timings, in milliseconds
    // ------------------------------------------------------------
    localparam logic [5:0] ACT_HALF_MS = 6'h32;
    localparam logic [11:0] SLOW_HALF_MS = 12'h258;
    localparam logic [11:0] CTX_BLIP_MS = 12'h04B;
    localparam logic [11:0] CTX_GAP_MS = 12'hBB8;
    localparam logic [11:0] FLASH_MS = 12'h1F4;
    localparam logic [9:0] XFER_HOLD_MS = 10'h3E8;

    // ------------------------------------------------------------
    // settings encodings
    // ------------------------------------------------------------
    localparam logic [1:0] DR_IGNORE = 2'h0;
    localparam logic [1:0] DR_CMD = 2'h1;
    localparam logic [1:0] DR_HANGUP = 2'h2;
    localparam logic [1:0] DR_RESET = 2'h3;
    localparam logic [1:0] FC_NONE = 2'h0;
    localparam logic [1:0] FC_HW = 2'h3;
    localparam int NUM_GPIO = 4;

    typedef enum logic [1:0] {LK_IDLE, LK_ONLINE, LK_DISC} mhsl_lk_t;
    typedef enum logic [2:0] {NM_OFF, NM_SEARCH, NM_CTX, NM_XFER, NM_CALL} mhsl_nm_t;

    // link-side status from the modem core, same clock
    typedef struct packed {
        logic fwd_ready;
        logic data_conn;
        logic dev_ready;
        logic full_duplex;
        logic link_good;
        logic traffic;
    } mhsl_link_t;

    // network registration and call status, same clock
    typedef struct packed {
        logic carrier_on;
        logic sleep;
        logic alarm;
        logic no_sim;
        logic no_pin;
        logic searching;
        logic authenticating;
        logic logging_in;
        logic ctx_active;
        logic pkt_seen;
        logic voice_conn;
        logic data_call_busy;
    } mhsl_net_t;

    typedef struct packed {
        logic [1:0] dtr_sync;
        logic dtr_off;
        mhsl_lk_t lk;
        logic cts_n;
        logic dcd_n;
        logic fdx_n;
        logic link_n;
        logic act_n;
        logic [5:0] act_ms;
        mhsl_nm_t nm;
        logic [1:0] nphase;
        logic [11:0] net_ms;
        logic net_n;
        logic xfer_live;
        logic [9:0] xfer_ms;
        logic hangup;
        logic cmd_mode;
        logic soft_reset;
        logic [NUM_GPIO-1:0] gdir;
        logic [NUM_GPIO-1:0] gout;
        logic [NUM_GPIO-1:0] gi1;
        logic [NUM_GPIO-1:0] gi2;
    } mhsl_st_t;

    localparam mhsl_st_t ST_RST = '{
        dtr_sync: 2'h3, dtr_off: 1'b1, lk: LK_IDLE, cts_n: 1'b1, dcd_n: 1'b1,
        fdx_n: 1'b1, link_n: 1'b1, act_n: 1'b1, nm: NM_OFF, net_n: 1'b1,
        default: '0};

endpackage : mhsl_pkg

/* File: mhsl_ms_tick.sv */
// millisecond tick generator
`timescale 1ns/10ps
`default_nettype none
module mhsl_ms_tick #(
    parameter int CYC_PER_MS = 40000
) (
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset, active high
    output logic tick // one-cycle pulse each millisecond
);
    localparam int W = $clog2(CYC_PER_MS);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic tick;
    } mhsl_tick_st_t;

    mhsl_tick_st_t st_q;
    mhsl_tick_st_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;
        if (st_q.cnt == W'(CYC_PER_MS - 1)) begin
            st_d.cnt = '0;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tick = st_q.tick;

    a_tick_single: assert property (@(posedge clk) disable iff (rst)
        st_q.tick |=> !st_q.tick)
        else $error("ms tick lasted more than one cycle");

endmodule : mhsl_ms_tick
`default_nettype wire

/* File: mhsl_host_model.sv */
// host terminal model: terminal-ready, transmit gating and pin wiring
`timescale 1ns/10ps
`default_nettype none
module mhsl_host_model import mhsl_pkg::*; (
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic cts_n, // clear to send from device
    input wire logic dtr_off, // bench asks to drop terminal-ready
    input wire logic tx_want, // bench has characters to send
    input wire logic [NUM_GPIO-1:0] gpio_o, // device pin level
    input wire logic [NUM_GPIO-1:0] gpio_oe, // device pin enable
    input wire logic [NUM_GPIO-1:0] ext_lvl, // outside source on the pins
    output logic dtr_n, // terminal-ready to device
    output logic tx_on, // a character goes out this cycle
    output logic [NUM_GPIO-1:0] pin // resolved pin level
);
    // ------------------------------------------------------------
    // host behaviour
    // ------------------------------------------------------------
    // a host that never drops terminal-ready leaves it tied low
    assign dtr_n = dtr_off;
    // clear-to-send is looked at once a cycle, like a uart between characters
    always_ff @(posedge clk) begin
        tx_on <= !rst && tx_want && !cts_n;
    end
    // the device wins the pin only while it enables it
    assign pin = (gpio_oe & gpio_o) | (~gpio_oe & ext_lvl);
endmodule : mhsl_host_model
`default_nettype wire

/* File: modem_handshake_status_leds_tb.sv */
// self-checking bench for the handshake and status indicator block
`timescale 1ns/10ps
`default_nettype none
module modem_handshake_status_leds_tb import mhsl_pkg::*;;
    // ------------------------------------------------------------
    // stimulus and wiring
    // ------------------------------------------------------------
    // short millisecond keeps the 3 s gap at 12000 cycles
    localparam int MSC = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] dr_set = DR_IGNORE;
    logic [1:0] fc_set = FC_HW;
    mhsl_link_t lnk = '0;
    mhsl_net_t net = '0;
    logic cfg_we = 1'b0;
    logic [NUM_GPIO-1:0] cfg_dir = '0;
    logic [NUM_GPIO-1:0] cfg_out = '0;
    logic [NUM_GPIO-1:0] ext_lvl = '0;
    logic dtr_off = 1'b0;
    logic tx_want = 1'b1;
    logic dtr_n, tx_on, cts_n, dcd_n, fdx_n, act_n, link_n, net_n, hup, cmdm, srst;
    logic [NUM_GPIO-1:0] g_o, g_oe, g_in, pin;
    logic [2:0] p;
    int failures = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n, k;

    always #12.5 clk = ~clk;

    mhsl_top #(.MS_CYCLES(MSC)) DUT (.clk(clk), .rst(rst), .dtr_n(dtr_n),
        .terminal_ready_response_setting(dr_set), .flow_control_setting(fc_set),
        .lnk(lnk), .net(net), .gpio_cfg_we(cfg_we), .gpio_cfg_dir(cfg_dir),
        .gpio_cfg_out(cfg_out), .gpio_i(pin), .cts_n(cts_n), .dcd_n(dcd_n),
        .duplex_indicator_n(fdx_n), .activity_indicator_n(act_n),
        .link_indicator_n(link_n), .net_led_n(net_n), .hangup_req(hup),
        .cmd_mode_req(cmdm), .soft_reset_req(srst), .gpio_o(g_o), .gpio_oe(g_oe),
        .gpio_in(g_in));

    mhsl_host_model host (.clk(clk), .rst(rst), .cts_n(cts_n), .dtr_off(dtr_off),
        .tx_want(tx_want), .gpio_o(g_o), .gpio_oe(g_oe), .ext_lvl(ext_lvl),
        .dtr_n(dtr_n), .tx_on(tx_on), .pin(pin));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize

    // sample a little after the edge so registered outputs have settled
    task automatic cyc_wait(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : cyc_wait

    function automatic logic led(input bit sel);
        return sel ? act_n : net_n;
    endfunction : led

    // length of the next full run at lvl; runs start and end on ticks
    task automatic run_len(input bit sel, input logic lvl, input int exp);
        int c;
        c = 0;
        while (led(sel) !== lvl && c < 20000) begin
            cyc_wait(1);
            c++;
        end
        c = 0;
        while (led(sel) === lvl && c < 20000) begin
            cyc_wait(1);
            c++;
        end
        chk(c, exp);
    endtask : run_len

    task automatic hold_chk(input bit sel, input logic lvl, input int cnt);
        int c;
        c = 0;
        repeat (cnt) begin
            cyc_wait(1);
            if (led(sel) === lvl) begin
                c++;
            end
        end
        chk(c, cnt);
    endtask : hold_chk

    always @(posedge clk) begin
        cyc++;
        if (cyc == 100000) begin
            failures++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        void'($urandom(72432));
        // reset is sampled high at the first two edges only
        cyc_wait(1);
        @(posedge clk);
        rst <= 1'b0;
        cyc_wait(1);
        chk({cts_n, dcd_n, fdx_n, act_n, link_n, net_n, hup, cmdm, srst, g_oe}, 13'h1F80);
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            lnk <= mhsl_link_t'(6'($urandom));
            fc_set <= (i < 20) ? FC_HW : FC_NONE;
            cyc_wait(4);
            chk(cts_n, (fc_set == FC_HW) ? !lnk.fwd_ready : 1'b0);
            chk(tx_on, !cts_n);
            chk(dcd_n, !(lnk.data_conn && lnk.dev_ready));
            chk({fdx_n, link_n}, {!lnk.full_duplex, !lnk.link_good});
        end
        $display("test handshake done");
        for (int s = 0; s < 4; s++) begin
            @(posedge clk);
            dr_set <= 2'(s);
            fc_set <= FC_HW;
            lnk <= '{fwd_ready: 1'b1, data_conn: 1'b1, dev_ready: 1'b1, default: 1'b0};
            dtr_off <= 1'b0;
            cyc_wait(6);
            chk(dcd_n, 1'b0);
            @(posedge clk);
            dtr_off <= 1'b1;
            k = 0;
            for (int c = 1; c <= 6; c++) begin
                cyc_wait(1);
                if (c == 3) begin
                    p = {hup, cmdm, srst};
                end
                if ({hup, cmdm, srst} !== 3'h0) begin
                    k++;
                end
            end
            chk(p, (s == 1) ? 3'h2 : (s == 2) ? 3'h4 : (s == 3) ? 3'h5 : 3'h0);
            chk(k, (s == 0) ? 0 : 1);
            chk({dcd_n, cts_n}, (s < 2) ? 2'h0 : 2'h3);
            @(posedge clk);
            lnk <= '0;
            dtr_off <= 1'b0;
            cyc_wait(6);
        end
        $display("test terminal ready done");
        @(posedge clk);
        lnk <= '{traffic: 1'b1, default: 1'b0};
        run_len(1'b1, 1'b0, 50 * MSC);
        run_len(1'b1, 1'b1, 50 * MSC);
        @(posedge clk);
        lnk <= '0;
        cyc_wait(2);
        chk(act_n, 1'b1);
        $display("test activity done");
        for (int q = 0; q < 3; q++) begin
            @(posedge clk);
            net <= '{carrier_on: q != 0, sleep: q == 1, alarm: q == 2, searching: 1'b1,
                voice_conn: 1'b1, default: 1'b0};
            hold_chk(1'b0, 1'b1, 3000);
        end
        for (int c = 4; c <= 8; c++) begin
            @(posedge clk);
            net <= '0;
            @(posedge clk);
            net <= mhsl_net_t'(12'h800 | (12'h001 << c));
            cyc_wait(2);
            chk(net_n, 1'b0);
        end
        run_len(1'b0, 1'b1, 600 * MSC);
        run_len(1'b0, 1'b0, 600 * MSC);
        @(posedge clk);
        net <= mhsl_net_t'(12'h848);
        cyc_wait(2);
        chk(net_n, 1'b0);
        run_len(1'b0, 1'b1, 75 * MSC);
        run_len(1'b0, 1'b0, 75 * MSC);
        run_len(1'b0, 1'b1, 3000 * MSC);
        // end inside a dark phase so the transfer check below has something to prove
        run_len(1'b0, 1'b0, 75 * MSC);
        @(posedge clk);
        net.pkt_seen <= 1'b1;
        n = 0;
        cyc_wait(1);
        while (net_n !== 1'b0 && n < 5000) begin
            cyc_wait(1);
            n++;
        end
        chk(n <= 1000 * MSC, 1'b1);
        run_len(1'b0, 1'b1, 500 * MSC);
        run_len(1'b0, 1'b0, 500 * MSC);
        for (int v = 0; v < 2; v++) begin
            @(posedge clk);
            net <= mhsl_net_t'((v == 0) ? 12'h84E : 12'h84D);
            hold_chk(1'b0, 1'b0, 3000);
        end
        $display("test network indicator done");
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            cfg_we <= 1'b1;
            cfg_dir <= 4'($urandom);
            cfg_out <= 4'($urandom);
            ext_lvl <= 4'($urandom);
            @(posedge clk);
            cfg_we <= 1'b0;
            cyc_wait(3);
            chk({g_oe, g_o}, {cfg_dir, cfg_out});
            chk(g_in, pin);
        end
        $display("test pins done");
        summarize();
    end
endmodule : modem_handshake_status_leds_tb
`default_nettype wire
